/* File: rtl/pse_event_flag_registers.sv */
// Purpose: Per-channel event flag registers with view and clear-on-read codes.
// Assumes: Read requests and events are synchronous to clk_sys.
// Notes:   Clear-on-read never drops an event arriving in the same cycle.
//
// What this block does
// - Detection/class register reads at 04h and 05h; 05h also clears it.
// - Fault register reads at 06h and 07h; 07h clears it.
// - Start/limit register reads at 08h and 09h; 09h clears it.
// - Supply register reads at 0Ah and 0Bh; 0Bh clears it.
// - Flags active high; channel turn-off clears its per-channel flags.
// - Clear-on-read of the register holding the interrupt releases it.
// - Any set event bit shows in its summary interrupt flag.
// - Class flags bits 7-4; class-change mode limits them to changes.
// - Detect flags bits 3-0; detect-change mode limits them to changes.
// - Fault register: disconnect bits 7-4, overload-duration bits 3-0.
// - Clearing overload flags leaves the duration counters untouched.
// - Limit flag bits 7-4 set after staying in limit past limit time.
// - Start flag bits 3-0 set on start fault while turning on.
// - Start fault without enable-change flag records its cause.
// - Autonomous mode: invalid discovery sets no start flag nor record.
// - Supply bits: thermal, lockout, warning, low supply, 2 rsvd, fast, memory.
// - Each summary bit 7-2 is the OR of its event bits; bits 1-0 stay 0.
// - Interrupt needs mask bit and global enable; summaries track anyway.
`timescale 1ns/1ns
`include "pse_event_regs.svh"

module pse_event_flag_registers #(
  parameter logic [15:0] LIM_CYCLES  = `LIM_CYCLES_DEF,
  parameter logic [15:0] OVLD_CYCLES = `OVLD_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // Register read port
  input  wire pse_event_pkg::rd_req_s  rd_req,
  output      pse_event_pkg::rd_rsp_s  rd_rsp,
  // Event sources
  input  wire pse_event_pkg::chan_evt_s chan_evt,
  input  wire logic [7:0]              supply_evt,
  input  wire logic [3:0]              power_enable_change_flag,
  input  wire logic                    auto_mode,
  // Mode and interrupt control
  input  wire logic                    class_change_mode,
  input  wire logic                    detect_change_mode,
  input  wire logic [7:0]              irq_mask,
  input  wire logic                    global_irq_enable,
  // Status outputs
  output      logic [7:0]              irq_summary,
  output      logic                    irq_n,
  output      logic [3:0]              pon_fault_record
);
  import pse_event_pkg::*;

  // ============================================================
  // State
  typedef struct packed {
    logic [7:0]       det;
    logic [7:0]       flt;
    logic [7:0]       sl;
    logic [7:0]       sup;
    logic [3:0][15:0] lim_cnt;
    logic [3:0][15:0] ovl_cnt;
    rd_rsp_s          rsp;
    logic [7:0]       summary;
    logic             irq_n;
    logic [3:0]       pon;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Saturating duration counter; the flag fires once when the count first passes the limit.
  function automatic logic [15:0] dur_next(input logic        active,
                                           input logic [15:0] cnt);
    if (!active)
      return 16'h0000;
    else if (cnt == 16'hFFFF)
      return cnt;
    else
      return cnt + 16'h0001;
  endfunction : dur_next

  // ============================================================
  // Next state
  logic [7:0] det_set;
  logic [7:0] flt_set;
  logic [7:0] sl_set;
  logic [7:0] sup_set;
  logic [7:0] chan_clr;
  logic [7:0] sum_d;
  logic [3:0] lim_hit;
  logic [3:0] ovl_hit;
  logic [3:0] start_ok;
  logic [7:0] rd_val;
  logic       rd_hit;

  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < 4; i++)
    begin
      s_d.lim_cnt[i] = dur_next(chan_evt.in_limit[i], s_q.lim_cnt[i]);
      s_d.ovl_cnt[i] = dur_next(chan_evt.in_overload[i], s_q.ovl_cnt[i]);
      lim_hit[i] = (s_d.lim_cnt[i] == LIM_CYCLES + 16'h0001);
      ovl_hit[i] = (s_d.ovl_cnt[i] == OVLD_CYCLES + 16'h0001);
    end
    det_set[7:4] = chan_evt.class_done
                 & (class_change_mode ? chan_evt.class_changed
                                      : 4'hF);
    det_set[3:0] = chan_evt.detect_done
                 & (detect_change_mode ? chan_evt.detect_changed
                                       : 4'hF);
    flt_set = {chan_evt.disconnect, ovl_hit};
    start_ok = chan_evt.start_fault
             & ~({4{auto_mode}} & chan_evt.discovery_invalid);
    sl_set = {lim_hit, start_ok};
    sup_set = supply_evt & ~`SUP_RSVD_MASK;
    chan_clr = {chan_evt.chan_off, chan_evt.chan_off};
    s_d.pon = start_ok & ~power_enable_change_flag;

    rd_hit = 1'b1;
    case (rd_req.cmd)
      `CMD_DET_VIEW, `CMD_DET_CLEAR: rd_val = s_q.det;
      `CMD_FLT_VIEW, `CMD_FLT_CLEAR: rd_val = s_q.flt;
      `CMD_SL_VIEW,  `CMD_SL_CLEAR:  rd_val = s_q.sl;
      `CMD_SUP_VIEW, `CMD_SUP_CLEAR: rd_val = s_q.sup;
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    s_d.rsp.valid = rd_req.req;
    s_d.rsp.data  = (rd_req.req && rd_hit) ? rd_val : 8'h00;

    // Clear first, then set, so a same-cycle event survives the clear.
    s_d.det = (s_q.det & ~chan_clr) | det_set;
    s_d.flt = (s_q.flt & ~chan_clr) | flt_set;
    s_d.sl  = (s_q.sl  & ~chan_clr) | sl_set;
    if (rd_req.req && rd_req.cmd == `CMD_DET_CLEAR)
      s_d.det = det_set;
    if (rd_req.req && rd_req.cmd == `CMD_FLT_CLEAR)
      s_d.flt = flt_set;
    if (rd_req.req && rd_req.cmd == `CMD_SL_CLEAR)
      s_d.sl = sl_set;
    if (rd_req.req && rd_req.cmd == `CMD_SUP_CLEAR)
      s_d.sup = sup_set;
    else
      s_d.sup = s_q.sup | sup_set;

    sum_d = 8'h00;
    sum_d[`SUM_SUPPLY] = |s_d.sup;
    sum_d[`SUM_START]  = |s_d.sl[3:0];
    sum_d[`SUM_IFAULT] = |s_d.sl[7:4] | (|s_d.flt[3:0]);
    sum_d[`SUM_CLASS]  = |s_d.det[7:4];
    sum_d[`SUM_DETECT] = |s_d.det[3:0];
    sum_d[`SUM_DISC]   = |s_d.flt[7:4];
    s_d.summary = sum_d;
    s_d.irq_n = ~(global_irq_enable && |(sum_d & irq_mask));
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q         <= '0;
      s_q.det     <= `EVT_RESET;
      s_q.flt     <= `EVT_RESET;
      s_q.sl      <= `EVT_RESET;
      s_q.sup     <= `SUP_RESET;
      s_q.summary <= 8'h80;
      s_q.irq_n   <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign rd_rsp           = s_q.rsp;
  assign irq_summary      = s_q.summary;
  assign irq_n            = s_q.irq_n;
  assign pon_fault_record = s_q.pon;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence clr_read_det;
    rd_req.req && rd_req.cmd == `CMD_DET_CLEAR && det_set == 8'h00;
  endsequence

  sequence view_read_det;
    rd_req.req && rd_req.cmd == `CMD_DET_VIEW && !(|chan_evt.chan_off);
  endsequence

  AST_DET_CLEAR: assert property (clr_read_det |=> s_q.det == 8'h00)
    else $error("detect clear-on-read left bits set");
  AST_DET_VIEW: assert property (view_read_det |=> s_q.det ==
                                 ($past(s_q.det) | $past(det_set)))
    else $error("detect view read altered register");
  AST_FLT_DATA: assert property (rd_req.req && (rd_req.cmd == `CMD_FLT_VIEW
                                 || rd_req.cmd == `CMD_FLT_CLEAR)
                                 |=> rd_rsp.valid
                                 && rd_rsp.data == $past(s_q.flt))
    else $error("fault register read data wrong");
  AST_SL_CLEAR: assert property (rd_req.req && rd_req.cmd == `CMD_SL_CLEAR
                                 |=> s_q.sl == $past(sl_set))
    else $error("start limit clear-on-read wrong");
  AST_SUP_KEEP: assert property (rd_req.req && rd_req.cmd == `CMD_SUP_CLEAR
                                 && supply_evt[1] |=> s_q.sup[1])
    else $error("supply event lost during clear");
  AST_SUP_RSVD: assert property (s_q.sup[3:2] == 2'b00)
    else $error("reserved supply bits set");
  AST_CHAN_OFF: assert property (chan_evt.chan_off[0]
                                 && !chan_evt.disconnect[0]
                                 |=> !s_q.flt[4])
    else $error("channel off did not clear disconnect flag");
  AST_SUMMARY: assert property (##1 s_q.summary[`SUM_DISC]
                                == (|s_q.flt[7:4]))
    else $error("disconnect summary mismatch");
  AST_IRQ: assert property (!global_irq_enable |=> irq_n)
    else $error("interrupt asserted without global enable");
  AST_AUTO: assert property (auto_mode && chan_evt.discovery_invalid[2]
                             |=> !pon_fault_record[2])
    else $error("invalid discovery recorded in auto mode");

endmodule : pse_event_flag_registers

/* File: rtl/pse_event_regs.svh */
// Purpose: Command codes, field positions and reset values of the event flags.
// Assumes: Eight-bit command codes and one data byte per register.
// Notes:   Definitions only.
`ifndef PSE_EVENT_REGS_SVH
`define PSE_EVENT_REGS_SVH

// ============================================================
// Command codes
`define CMD_DET_VIEW    8'h04
`define CMD_DET_CLEAR   8'h05
`define CMD_FLT_VIEW    8'h06
`define CMD_FLT_CLEAR   8'h07
`define CMD_SL_VIEW     8'h08
`define CMD_SL_CLEAR    8'h09
`define CMD_SUP_VIEW    8'h0A
`define CMD_SUP_CLEAR   8'h0B

// ============================================================
// Field positions and reset values
`define UPPER_LSB       4
`define LOWER_LSB       0
`define EVT_RESET       8'h00
`define SUP_RESET       8'h70
`define SUP_RSVD_MASK   8'h0C

// ============================================================
// Summary interrupt bit positions
`define SUM_SUPPLY      3'd7
`define SUM_START       3'd6
`define SUM_IFAULT      3'd5
`define SUM_CLASS       3'd4
`define SUM_DETECT      3'd3
`define SUM_DISC        3'd2

// ============================================================
// Duration counter defaults
`define LIM_CYCLES_DEF  16'd1000
`define OVLD_CYCLES_DEF 16'd1000

`endif

/* File: rtl/pse_event_pkg.sv */
// Purpose: Types shared by the event flag register bank.
// Assumes: Four channels per register.
// Notes:   Constants live in pse_event_regs.svh.
package pse_event_pkg;

  // ============================================================
  // Per-channel event inputs from the port engine
  typedef struct packed {
    logic [3:0] detect_done;
    logic [3:0] detect_changed;
    logic [3:0] class_done;
    logic [3:0] class_changed;
    logic [3:0] disconnect;
    logic [3:0] in_overload;
    logic [3:0] in_limit;
    logic [3:0] start_fault;
    logic [3:0] discovery_invalid;
    logic [3:0] chan_off;
  } chan_evt_s;

  // ============================================================
  // Register read request and answer
  typedef struct packed {
    logic       req;
    logic [7:0] cmd;
  } rd_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rd_rsp_s;

endpackage : pse_event_pkg

/* File: verif/host_model.sv */
// Purpose: Host model that issues single register reads.
// Assumes: One read in flight; the answer comes one cycle after the request.
// Notes:   Released command lines carry the inverse of the last code.
`timescale 1ns/1ns
module host_model
(
  // Clock
  input  wire logic                   clk_sys,
  // Read port
  output      pse_event_pkg::rd_req_s rd_req,
  input  wire pse_event_pkg::rd_rsp_s rd_rsp
);
  import pse_event_pkg::*;

  // ============================================================
  // Read cycle
  initial rd_req = '0;

  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(negedge clk_sys);
    rd_req = '{req: 1'b1, cmd: c};
    @(negedge clk_sys);
    rd_req = '{req: 1'b0, cmd: ~c};
    d = rd_rsp.valid ? rd_rsp.data : 8'hXX;
  endtask : rd

  // A start fault seen with the enable-change flag counts as inrush.
  function automatic logic [3:0] inrush(input logic [3:0] s, p);
    return s & p;
  endfunction : inrush
endmodule : host_model

/* File: verif/pse_event_flag_registers_tb_top.sv */
// Purpose: Self-checking bench for the event flag registers.
// Assumes: Duration limits shortened to 5 cycles.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ns
module pse_event_flag_registers_tb_top;
  import pse_event_pkg::*;
  logic       clk_sys, rst_n, auto, ccm, dcm, gie, irq_n;
  logic [7:0] sup, mask, summ;
  logic [3:0] pec, pon;
  rd_req_s    rq;
  rd_rsp_s    rs;
  chan_evt_s  ev, e;
  int         err_count, comparisons;

  pse_event_flag_registers #(.LIM_CYCLES(16'h0005), .OVLD_CYCLES(16'h0005))
    pse_event_flag_registers_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .rd_req(rq), .rd_rsp(rs), .chan_evt(ev), .supply_evt(sup),
    .power_enable_change_flag(pec), .auto_mode(auto),
    .class_change_mode(ccm), .detect_change_mode(dcm), .irq_mask(mask),
    .global_irq_enable(gie), .irq_summary(summ), .irq_n(irq_n),
    .pon_fault_record(pon));
  host_model host_model_inst (.clk_sys(clk_sys), .rd_req(rq), .rd_rsp(rs));

  // ============================================================
  // Checking helpers
  task automatic chk(input string n, input logic [7:0] s, x);
    comparisons++;
    if (s !== x)
    begin
      err_count++;
      $display("unexpected %s exp %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] c, x);
    logic [7:0] d;
    host_model_inst.rd(c, d);
    chk($sformatf("cmd %h", c), d, x);
  endtask : rdc

  task automatic pulse(input chan_evt_s p, input logic [7:0] s);
    @(negedge clk_sys);
    ev = p;
    sup = s;
    @(negedge clk_sys);
    ev = '0;
    sup = 8'h00;
  endtask : pulse

  // Holds a level input for n clock edges, then drops every channel event line.
  task automatic hold(input chan_evt_s p, input int n);
    @(negedge clk_sys);
    ev = p;
    repeat (n) @(negedge clk_sys);
    ev = '0;
  endtask : hold

  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ============================================================
  // Scenarios
  task automatic t_irq;
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    chk("summary", summ, 8'h80);
    gie = 1'b1;
    rdc(8'h0A, 8'h70);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    mask = 8'h80;
    rdc(8'h04, 8'h00);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    rdc(8'h0B, 8'h70);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    pulse('0, 8'h8D);
    rdc(8'h0A, 8'h81);
    rdc(8'h0B, 8'h81);
    rdc(8'h0A, 8'h00);
    fork
      rdc(8'h0B, 8'h00);
      pulse('0, 8'h02);
    join
    rdc(8'h0B, 8'h02);
    $display("irq test done");
  endtask : t_irq

  task automatic t_detect;
    e = '0;
    e.detect_done = 4'h1;
    e.class_done = 4'h4;
    pulse(e, 8'h00);
    rdc(8'h04, 8'h41);
    chk("summary", summ, 8'h18);
    rdc(8'h05, 8'h41);
    rdc(8'h04, 8'h00);
    dcm = 1'b1;
    ccm = 1'b1;
    e.class_changed = 4'h4;
    pulse(e, 8'h00);
    rdc(8'h05, 8'h40);
    dcm = 1'b0;
    ccm = 1'b0;
    e = '0;
    e.detect_done = 4'h1;
    fork
      rdc(8'h05, 8'h00);
      pulse(e, 8'h00);
    join
    rdc(8'h05, 8'h01);
    $display("detect test done");
  endtask : t_detect

  task automatic t_fault;
    e = '0;
    e.disconnect = 4'h2;
    pulse(e, 8'h00);
    e = '0;
    e.in_overload = 4'h1;
    hold(e, 8);
    rdc(8'h06, 8'h21);
    rdc(8'h07, 8'h21);
    rdc(8'h06, 8'h00);
    e = '0;
    e.start_fault = 4'h8;
    pec = 4'h8;
    pulse(e, 8'h00);
    chk("pon", {4'h0, pon}, 8'h00);
    pec = 4'h0;
    pulse(e, 8'h00);
    chk("pon", {4'h0, pon}, 8'h08);
    e.start_fault = 4'h4;
    e.discovery_invalid = 4'h4;
    auto = 1'b1;
    pulse(e, 8'h00);
    chk("pon", {4'h0, pon}, 8'h00);
    e = '0;
    e.in_limit = 4'h2;
    hold(e, 8);
    rdc(8'h08, 8'h28);
    rdc(8'h09, 8'h28);
    rdc(8'h08, 8'h00);
    e = '0;
    e.detect_done = 4'h2;
    e.disconnect = 4'h3;
    pulse(e, 8'h00);
    e = '0;
    e.chan_off = 4'h3;
    pulse(e, 8'h00);
    rdc(8'h04, 8'h00);
    rdc(8'h06, 8'h00);
    rdc(8'h20, 8'h00);
    $display("fault test done");
  endtask : t_fault

  // ============================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    {rst_n, auto, ccm, dcm, gie, sup, mask, pec} = '0;
    ev = '0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    t_irq();
    t_detect();
    t_fault();
    close_out();
  end

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    close_out();
  end
endmodule : pse_event_flag_registers_tb_top
